// ===== ssf_front_end.sv
// serial memory slave front end: framing, pause, shifting, write buffer
//
// Contract
// - deselected: standby, ignore input, output released
// - array write cycle completes on select rising
// - nothing accepted before first select falling edge
// - input bits captured on clock rising edges
// - read output changes only after falling edges
// - pause starts clock low, else next fall
// - pause release likewise waits for clock low
// - paused: clock and input transitions ignored
// - output released and driven following pause pin
// - array writes continuous or 64-byte pages by status
// - rollover bit zero wraps within page
// - two-byte user space, no address bytes
// - short user-space write aborted, value kept
// - user-space read may stop early
// - user space volatile, exported for storing
// - status writable bits volatile, recall overwrites
// - all bytes shifted most significant first
// - first bit on first rise after select
// - read data starts at fall after instruction, or after address for array read
// - first byte after select is instruction
// - select rising while paused aborts, clears latch
`timescale 1ns/1ps

module ssf_front_end #(
    parameter int ADDR_W = ssf_pkg::ADDR_W,
    parameter int DATA_W = ssf_pkg::DATA_W
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 cs_n,
    input  wire logic                 sck,
    input  wire logic                 si,
    input  wire logic                 hold_n,
    output logic                      so_o,
    output logic                      so_oe,
    output logic                      mw_valid,
    input  wire logic                 mw_ready,
    output logic [ADDR_W-1:0]         mw_addr,
    output logic [DATA_W-1:0]         mw_data,
    output logic [ADDR_W-1:0]         rd_addr,
    input  wire logic [DATA_W-1:0]    rd_data,
    input  wire logic                 recall_req,
    input  wire logic [7:0]           recall_status,
    input  wire logic [15:0]          recall_user,
    output logic [7:0]                status_o,
    output logic [15:0]               user_o,
    output logic                      wr_done
);

    localparam int ENT_W = ADDR_W + DATA_W;
    localparam int RB    = ssf_pkg::SR_ROLLOVER_BIT;
    localparam int WB    = ssf_pkg::SR_WR_LATCH_BIT;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]          cs_sy;
        logic [1:0]          sck_sy;
        logic [1:0]          si_sy;
        logic [1:0]          hold_sy;
        logic                cs_d;
        logic                sck_d;
        logic                armed;
        logic                paused;
        ssf_pkg::ssf_phase_e phase;
        logic [7:0]          opc;
        logic [2:0]          bitcnt;
        logic [1:0]          bytecnt;
        logic [7:0]          rx;
        logic [7:0]          tx;
        logic [ADDR_W-1:0]   addr;
        logic [7:0]          sr;
        logic [15:0]         user;
        logic [7:0]          sr_stage;
        logic [15:0]         user_stage;
        logic                stage_ok;
        logic                pend;
        logic [ENT_W-1:0]    pend_w;
        logic [1:0]          fv;
        logic [ENT_W-1:0]    f0;
        logic [ENT_W-1:0]    f1;
        logic                so;
        logic                so_oe;
        logic                wr_done;
    } ssf_regs_s;

    // select sync resets to "low" so a pin already low at power-up gives no fall
    localparam ssf_regs_s RST_S = '{phase:   ssf_pkg::PH_IDLE,
                                    sr:      ssf_pkg::SR_RST,
                                    user:    ssf_pkg::USER_RST,
                                    hold_sy: 2'b11,
                                    default: '0};

    ssf_regs_s          st_r;
    ssf_regs_s          st_nxt;

    logic               cs_w;
    logic               sck_w;
    logic               hold_l_w;
    logic               sel_w;
    logic               cs_fall_w;
    logic               cs_rise_w;
    logic               act_rise_w;
    logic               act_fall_w;
    logic               byte_w;
    logic               wpush_w;
    logic [7:0]         rx_w;
    logic [ADDR_W-1:0]  wnext_w;

    // ------------------------------------------------------------------
    // edge and frame decode
    // ------------------------------------------------------------------
    // the clock pin is a plain input sampled here
    assign cs_w       = st_r.cs_sy[1];
    assign sck_w      = st_r.sck_sy[1];
    assign hold_l_w   = ~st_r.hold_sy[1];
    assign sel_w      = st_r.armed & ~cs_w;
    assign cs_fall_w  = st_r.cs_d & ~cs_w;
    assign cs_rise_w  = st_r.armed & cs_w & ~st_r.cs_d;
    assign act_rise_w = sel_w & ~st_r.paused & sck_w & ~st_r.sck_d;
    assign act_fall_w = sel_w & ~st_r.paused & ~sck_w & st_r.sck_d;
    assign rx_w       = {st_r.rx[6:0], st_r.si_sy[1]};
    assign byte_w     = act_rise_w & (st_r.bitcnt == 3'h7);
    assign wpush_w    = byte_w & (st_r.phase == ssf_pkg::PH_WDATA) & st_r.sr[WB];
    // page mode keeps the upper bits and wraps the low six
    assign wnext_w    = st_r.sr[RB] ? ADDR_W'(st_r.addr + 1'b1)
                      : {st_r.addr[ADDR_W-1:ssf_pkg::PAGE_W],
                         st_r.addr[ssf_pkg::PAGE_W-1:0] + 6'h01};

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic             v0;
        logic             v1;
        logic             want_v;
        logic [ENT_W-1:0] e0;
        logic [ENT_W-1:0] e1;
        logic [ENT_W-1:0] want;
        logic [7:0]       ob;
        v0     = st_r.fv[0];
        v1     = st_r.fv[1];
        e0     = st_r.f0;
        e1     = st_r.f1;
        want_v = 1'b0;
        want   = '0;
        ob     = 8'h00;
        st_nxt = st_r;

        // first stages feed only the second stages
        st_nxt.cs_sy   = {st_r.cs_sy[0], cs_n};
        st_nxt.sck_sy  = {st_r.sck_sy[0], sck};
        st_nxt.si_sy   = {st_r.si_sy[0], si};
        st_nxt.hold_sy = {st_r.hold_sy[0], hold_n};
        st_nxt.cs_d    = cs_w;
        st_nxt.sck_d   = sck_w;
        st_nxt.wr_done = 1'b0;
        if (cs_fall_w)
            st_nxt.armed = 1'b1;

        // pause follows the pin only while the clock is low
        if (!sel_w)
            st_nxt.paused = 1'b0;
        else if (!sck_w)
            st_nxt.paused = hold_l_w;

        // output enable tracks the pause pin directly, not the pause state
        st_nxt.so_oe = sel_w & ~hold_l_w & (st_r.phase == ssf_pkg::PH_SOUT);

        if (!sel_w)
        begin
            st_nxt.phase   = ssf_pkg::PH_IDLE;
            st_nxt.bitcnt  = 3'h0;
            st_nxt.bytecnt = 2'h0;
        end
        else if (st_r.phase == ssf_pkg::PH_IDLE)
            st_nxt.phase = ssf_pkg::PH_CMD;

        if (act_rise_w)
        begin
            st_nxt.rx     = rx_w;
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
        end

        if (byte_w)
        begin
            case (st_r.phase)
                ssf_pkg::PH_CMD:
                begin
                    st_nxt.opc     = rx_w;
                    st_nxt.bytecnt = 2'h0;
                    if (rx_w == ssf_pkg::OP_ARRAY_READ || rx_w == ssf_pkg::OP_ARRAY_WRITE)
                        st_nxt.phase = ssf_pkg::PH_ADDR;
                    else if (rx_w == ssf_pkg::OP_STATUS_READ || rx_w == ssf_pkg::OP_USER_READ)
                        st_nxt.phase = ssf_pkg::PH_SOUT;
                    else if (rx_w == ssf_pkg::OP_STATUS_WRITE)
                        st_nxt.phase = ssf_pkg::PH_SR_IN;
                    else if (rx_w == ssf_pkg::OP_USER_WRITE)
                        st_nxt.phase = ssf_pkg::PH_USER_IN;
                    else
                        st_nxt.phase = ssf_pkg::PH_DONE;
                end
                ssf_pkg::PH_ADDR:
                begin
                    if (st_r.bytecnt == 2'h0)
                    begin
                        st_nxt.addr[ADDR_W-1:8] = rx_w[ADDR_W-9:0];
                        st_nxt.bytecnt          = 2'h1;
                    end
                    else
                    begin
                        st_nxt.addr[7:0] = rx_w;
                        st_nxt.bytecnt   = 2'h0;
                        st_nxt.phase     = (st_r.opc == ssf_pkg::OP_ARRAY_READ)
                                         ? ssf_pkg::PH_SOUT : ssf_pkg::PH_WDATA;
                    end
                end
                ssf_pkg::PH_WDATA:
                begin
                    if (st_r.sr[WB])
                        st_nxt.addr = wnext_w;
                end
                ssf_pkg::PH_SR_IN:
                begin
                    st_nxt.sr_stage = rx_w;
                    st_nxt.stage_ok = 1'b1;
                    st_nxt.phase    = ssf_pkg::PH_DONE;
                end
                ssf_pkg::PH_USER_IN:
                begin
                    if (st_r.bytecnt == 2'h0)
                    begin
                        st_nxt.user_stage[15:8] = rx_w;
                        st_nxt.bytecnt          = 2'h1;
                    end
                    else
                    begin
                        st_nxt.user_stage[7:0] = rx_w;
                        st_nxt.stage_ok        = 1'b1;
                        st_nxt.phase           = ssf_pkg::PH_DONE;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // a fresh byte is taken on the first fall of each byte slot
        if (act_fall_w && st_r.phase == ssf_pkg::PH_SOUT)
        begin
            if (st_r.bitcnt == 3'h0)
            begin
                if (st_r.opc == ssf_pkg::OP_ARRAY_READ)
                    ob = rd_data;
                else if (st_r.opc == ssf_pkg::OP_STATUS_READ)
                    ob = st_r.sr;
                else
                    ob = st_r.bytecnt[0] ? st_r.user[7:0] : st_r.user[15:8];
                st_nxt.so = ob[7];
                st_nxt.tx = {ob[6:0], 1'b0};
                if (st_r.opc == ssf_pkg::OP_ARRAY_READ)
                    st_nxt.addr = ADDR_W'(st_r.addr + 1'b1);
                if (st_r.opc == ssf_pkg::OP_USER_READ)
                    st_nxt.bytecnt = st_r.bytecnt ^ 2'h1;
            end
            else
            begin
                st_nxt.so = st_r.tx[7];
                st_nxt.tx = {st_r.tx[6:0], 1'b0};
            end
        end

        // frame end: commit staged writes, or abort when still paused
        if (cs_rise_w)
        begin
            st_nxt.stage_ok = 1'b0;
            if (st_r.paused)
                st_nxt.sr[WB] = 1'b0;
            else if (st_r.phase != ssf_pkg::PH_CMD && st_r.phase != ssf_pkg::PH_IDLE)
            begin
                if (st_r.opc == ssf_pkg::OP_WR_ENABLE)
                    st_nxt.sr[WB] = 1'b1;
                else if (st_r.opc == ssf_pkg::OP_WR_DISABLE)
                    st_nxt.sr[WB] = 1'b0;
                else if (st_r.opc == ssf_pkg::OP_ARRAY_WRITE && st_r.sr[WB] &&
                         st_r.phase == ssf_pkg::PH_WDATA)
                begin
                    st_nxt.sr[WB]  = 1'b0;
                    st_nxt.wr_done = 1'b1;
                end
                else if (st_r.opc == ssf_pkg::OP_STATUS_WRITE && st_r.stage_ok && st_r.sr[WB])
                begin
                    st_nxt.sr = (st_r.sr & ~ssf_pkg::SR_WMASK) |
                                (st_r.sr_stage & ssf_pkg::SR_WMASK);
                    st_nxt.sr[WB] = 1'b0;
                end
                else if (st_r.opc == ssf_pkg::OP_USER_WRITE && st_r.stage_ok)
                    st_nxt.user = st_r.user_stage;
            end
        end

        if (recall_req)
        begin
            st_nxt.sr   = (st_nxt.sr & ~ssf_pkg::SR_WMASK) |
                          (recall_status & ssf_pkg::SR_WMASK);
            st_nxt.user = recall_user;
        end

        // two-entry write buffer; a held word waits in pend for space
        if (v0 && mw_ready)
        begin
            e0 = e1;
            v0 = v1;
            v1 = 1'b0;
        end
        want_v      = st_r.pend | wpush_w;
        want        = st_r.pend ? st_r.pend_w : {st_r.addr, rx_w};
        st_nxt.pend = 1'b0;
        if (want_v)
        begin
            if (!v0)
            begin
                e0 = want;
                v0 = 1'b1;
            end
            else if (!v1)
            begin
                e1 = want;
                v1 = 1'b1;
            end
            else
            begin
                st_nxt.pend   = 1'b1;
                st_nxt.pend_w = want;
            end
        end
        if (st_r.pend && wpush_w && !st_nxt.pend)
        begin
            st_nxt.pend   = 1'b1;
            st_nxt.pend_w = {st_r.addr, rx_w};
        end
        st_nxt.fv = {v1, v0};
        st_nxt.f0 = e0;
        st_nxt.f1 = e1;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_r <= RST_S;
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign so_o     = st_r.so;
    assign so_oe    = st_r.so_oe;
    assign mw_valid = st_r.fv[0];
    assign mw_addr  = st_r.f0[ENT_W-1:DATA_W];
    assign mw_data  = st_r.f0[DATA_W-1:0];
    assign rd_addr  = st_r.addr;
    assign status_o = st_r.sr;
    assign user_o   = st_r.user;
    assign wr_done  = st_r.wr_done;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_frame_end_paused;
        cs_rise_w && st_r.paused;
    endsequence

    sequence s_array_write_end;
        cs_rise_w && !st_r.paused && st_r.opc == ssf_pkg::OP_ARRAY_WRITE &&
        st_r.phase == ssf_pkg::PH_WDATA && st_r.sr[WB];
    endsequence

    property p_deselect_release;
        !sel_w |=> !st_r.so_oe;
    endproperty
    a_deselect_release: assert property (p_deselect_release)
        else $error("output driven while deselected");

    property p_write_on_cs_rise;
        s_array_write_end |=> st_r.wr_done && !st_r.sr[WB] ##1 !st_r.wr_done;
    endproperty
    a_write_on_cs_rise: assert property (p_write_on_cs_rise)
        else $error("array write not completed on select rising");

    property p_unarmed_idle;
        !st_r.armed |-> st_r.phase == ssf_pkg::PH_IDLE && !st_r.so_oe;
    endproperty
    a_unarmed_idle: assert property (p_unarmed_idle)
        else $error("activity before first select fall");

    property p_bits_on_rise;
        sel_w && $past(sel_w) && st_r.bitcnt != $past(st_r.bitcnt) |-> $past(act_rise_w);
    endproperty
    a_bits_on_rise: assert property (p_bits_on_rise)
        else $error("bit counted without clock rise");

    property p_out_on_fall;
        st_r.so != $past(st_r.so) |-> $past(act_fall_w);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("output changed without clock fall");

    property p_pause_low_clock;
        sel_w && !sck_w && hold_l_w |=> st_r.paused;
    endproperty
    a_pause_low_clock: assert property (p_pause_low_clock)
        else $error("pause not taken with clock low");

    property p_pause_high_clock;
        sel_w && sck_w |=> st_r.paused == $past(st_r.paused);
    endproperty
    a_pause_high_clock: assert property (p_pause_high_clock)
        else $error("pause changed while clock high");

    property p_paused_ignores;
        st_r.paused && sel_w |=> st_r.bitcnt == $past(st_r.bitcnt) &&
                                st_r.rx == $past(st_r.rx);
    endproperty
    a_paused_ignores: assert property (p_paused_ignores)
        else $error("input taken while paused");

    property p_pause_pin_release;
        !st_r.hold_sy[1] |=> !st_r.so_oe;
    endproperty
    a_pause_pin_release: assert property (p_pause_pin_release)
        else $error("output driven with pause pin low");

    property p_page_wrap;
        wpush_w && !st_r.sr[RB] && (&st_r.addr[ssf_pkg::PAGE_W-1:0]) |=>
            st_r.addr[ssf_pkg::PAGE_W-1:0] == 6'h00 &&
            st_r.addr[ADDR_W-1:ssf_pkg::PAGE_W] == $past(st_r.addr[ADDR_W-1:ssf_pkg::PAGE_W]);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page mode write did not wrap");

    property p_user_abort;
        cs_rise_w && st_r.opc == ssf_pkg::OP_USER_WRITE && !st_r.stage_ok && !recall_req
            |=> st_r.user == $past(st_r.user);
    endproperty
    a_user_abort: assert property (p_user_abort)
        else $error("short user write changed value");

    property p_hold_abort;
        s_frame_end_paused |=> !st_r.sr[WB] && !st_r.wr_done;
    endproperty
    a_hold_abort: assert property (p_hold_abort)
        else $error("paused frame end did not abort");

endmodule

// ===== ssf_front_end_tb_top.sv
// testbench: random and corner frames through the serial memory front end
`timescale 1ns/1ps

module ssf_front_end_tb_top;
    logic        clk, sys_rst, cs_n, sck, si, hold_n, so_o, so_oe;
    logic        mw_valid, mw_ready, recall_req, wr_done;
    logic [14:0] mw_addr, rd_addr, a;
    logic [7:0]  mw_data, rd_data, recall_status, status_o, lfsr, b;
    logic [15:0] recall_user, user_o, v;
    logic [23:0] q;
    logic [7:0]  mem [0:32767];
    logic [7:0]  ed [$];
    int          err_total, checked, done_cnt, n0, k;

    ssf_front_end ssf_front_end_i (.clk, .sys_rst, .cs_n, .sck, .si, .hold_n, .so_o,
        .so_oe, .mw_valid, .mw_ready, .mw_addr, .mw_data, .rd_addr, .rd_data,
        .recall_req, .recall_status, .recall_user, .status_o, .user_o, .wr_done);
    ssf_spi_master ssf_spi_master_i (.clk, .so_o, .so_oe, .cs_n, .sck, .si, .hold_n);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [14:0] nxt(input logic [14:0] x, input logic page_rollover_select);
        return page_rollover_select ? x + 15'h1 : {x[14:6], x[5:0] + 6'h1};
    endfunction

    // memory partner with random write stalls
    always @(posedge clk)
    begin
        lfsr     <= lfsr_next(lfsr);
        mw_ready <= lfsr[0] | lfsr[3];
        rd_data  <= mem[rd_addr];
        if (mw_valid && mw_ready)
            mem[mw_addr] <= mw_data;
        if (wr_done)
            done_cnt <= done_cnt + 1;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic sx(input int n, input logic [23:0] d);
        ssf_spi_master_i.xfer(n, d, q);
    endtask

    task automatic frame(input int n, input logic [23:0] d);
        ssf_spi_master_i.sel();
        sx(n, d);
        ssf_spi_master_i.desel();
    endtask

    task automatic wr(input logic [14:0] at, input int n, input logic page_rollover_select);
        ed.delete();
        n0 = done_cnt;
        frame(8, 24'(ssf_pkg::OP_WR_ENABLE));
        ssf_spi_master_i.sel();
        sx(24, {ssf_pkg::OP_ARRAY_WRITE, 1'b0, at});
        for (int i = 0; i < n; i++)
        begin
            b = lfsr;
            ed.push_back(b);
            sx(8, 24'(b));
        end
        ssf_spi_master_i.desel();
        k = 0;
        while ((done_cnt == n0 || mw_valid !== 1'b0) && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 400)
        begin
            err_total++;
            $display("[ERR] %0t write never drained", $time);
            test_done();
        end
        @(posedge clk);
        chk(16'(done_cnt - n0), 16'h1);
        chk(16'(status_o[1]), 16'h0);
        for (int i = 0; i < n; i++)
        begin
            chk(16'(mem[at]), 16'(ed[i]));
            at = nxt(at, page_rollover_select);
        end
    endtask

    initial
    begin
        sys_rst = 1'b1;
        mw_ready = 1'b0;
        rd_data = 8'h00;
        recall_req = 1'b0;
        recall_status = 8'h00;
        recall_user = 16'h0000;
        lfsr = 8'h62;
        err_total = 0;
        checked = 0;
        done_cnt = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(16'(status_o), 16'(ssf_pkg::SR_RST));
        chk(16'(so_oe), 16'h0);
        wr(15'h003e, 3, 1'b0);
        frame(8, 24'(ssf_pkg::OP_WR_ENABLE));
        frame(16, {8'h00, ssf_pkg::OP_STATUS_WRITE, 8'h33});
        chk(16'(status_o), 16'(8'h33 & ssf_pkg::SR_WMASK));
        a = {lfsr[6:0], 8'hfe};
        wr(a, 3, 1'b1);
        // read back with a pause inside the second byte
        ssf_spi_master_i.sel();
        sx(24, {ssf_pkg::OP_ARRAY_READ, 1'b0, a});
        sx(8, 24'h0);
        chk(16'(q[7:0]), 16'(ed[0]));
        sx(3, 24'h0);
        b = q[7:0];
        ssf_spi_master_i.hold(1'b0);
        chk(16'(so_oe), 16'h0);
        sx(2, 24'h3);
        ssf_spi_master_i.hold(1'b1);
        chk(16'(so_oe), 16'h1);
        sx(5, 24'h0);
        chk(16'({b[2:0], q[4:0]}), 16'(ed[1]));
        ssf_spi_master_i.desel();
        chk(16'(so_oe), 16'h0);
        // pause abort in mid-write
        n0 = done_cnt;
        frame(8, 24'(ssf_pkg::OP_WR_ENABLE));
        chk(16'(status_o[1]), 16'h1);
        ssf_spi_master_i.sel();
        sx(24, {ssf_pkg::OP_ARRAY_WRITE, 16'h0000});
        sx(8, 24'ha5);
        ssf_spi_master_i.hold(1'b0);
        ssf_spi_master_i.desel();
        ssf_spi_master_i.hold(1'b1);
        chk(16'(status_o[1]), 16'h0);
        chk(16'(done_cnt - n0), 16'h0);
        // user space: full write, short write, early-ended read
        v = {lfsr, ~lfsr};
        frame(24, {ssf_pkg::OP_USER_WRITE, v});
        chk(user_o, v);
        frame(20, {ssf_pkg::OP_USER_WRITE, ~v} >> 4);
        chk(user_o, v);
        frame(16, {8'h00, ssf_pkg::OP_USER_READ, 8'h00});
        chk(16'(q[7:0]), 16'(v[15:8]));
        @(posedge clk);
        recall_req <= 1'b1;
        recall_status <= 8'hff;
        recall_user <= ~v;
        @(posedge clk);
        recall_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk(16'(status_o), 16'(ssf_pkg::SR_WMASK));
        chk(user_o, ~v);
        test_done();
    end
endmodule

// ===== ssf_pkg.sv
// constants and types shared by the serial memory slave front end
package ssf_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 15;
    localparam int DATA_W    = 8;
    localparam int PAGE_W    = 6;
    localparam int USER_W    = 16;

    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WR_ENABLE    = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE   = 8'h04;
    localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
    localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_USER_WRITE   = 8'hc2;
    localparam logic [7:0] OP_USER_READ    = 8'hc3;

    // ------------------------------------------------------------------
    // status byte layout and reset values
    // ------------------------------------------------------------------
    localparam int         SR_ROLLOVER_BIT = 5;
    localparam int         SR_WR_LATCH_BIT = 1;
    localparam logic [7:0] SR_WMASK        = 8'hec;
    localparam logic [7:0] SR_RST          = 8'h00;
    localparam logic [15:0] USER_RST       = 16'h0000;

    // ------------------------------------------------------------------
    // frame phases
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        PH_IDLE    = 8'h01,
        PH_CMD     = 8'h02,
        PH_ADDR    = 8'h04,
        PH_WDATA   = 8'h08,
        PH_SOUT    = 8'h10,
        PH_SR_IN   = 8'h20,
        PH_USER_IN = 8'h40,
        PH_DONE    = 8'h80
    } ssf_phase_e;

endpackage

// ===== ssf_spi_master.sv
// spi master model driving select, clock, data and pause pins
`timescale 1ns/1ps

module ssf_spi_master (
    input  wire logic clk,
    input  wire logic so_o,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    logic so_last;
    // a released line shows the inverse of its last level, never a stale copy
    wire  so_line = so_oe ? so_o : ~so_last;

    initial
    begin
        cs_n    = 1'b1;
        sck     = 1'b0;
        si      = 1'b0;
        hold_n  = 1'b1;
        so_last = 1'b0;
    end

    always @(posedge clk)
        if (so_oe)
            so_last <= so_o;

    task automatic sel();
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic desel();
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    // only called with the clock low; the release after the mid-write abort comes once the device is deselected
    task automatic hold(input logic v);
        @(posedge clk);
        hold_n <= v;
        repeat (6) @(posedge clk);
    endtask

    // mode 0: low half then high half per bit, data read back at the rise
    task automatic xfer(input int n, input logic [23:0] d, output logic [23:0] q);
        q = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clk);
            si <= d[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            q = {q[22:0], so_line};
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
    endtask
endmodule
